// ==== core/boundary_scan_test_port.v ====
// Boundary-scan test access port: TAP controller, instruction and data registers.
`timescale 1ns/100ps
`include "scan_port_defines.vh"
module boundary_scan_test_port #(
    parameter BSR_LEN = `BSR_LEN_DEFAULT,
    parameter STAGE_CYCLES = `ISP_STAGE_CYCLES,
    parameter [31:0] USER_CODE = `USER_CODE_DEFAULT,
    // Identity fields are arbitrary values, not those of any real part.
    parameter [3:0] ID_VERSION = `ID_VERSION,
    parameter [15:0] ID_PART = `ID_PART,
    parameter [10:0] ID_MAKER = `ID_MAKER
) (
    input wire clock,
    input wire resetn,
    input wire port_enable,
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo,
    output reg tdo_oe,
    input wire [3:0] user_pin_in,
    output reg [3:0] user_pin_out,
    output reg [3:0] user_pin_oe,
    input wire [BSR_LEN-1:0] core_out,
    input wire [BSR_LEN-1:0] pin_in,
    output reg [BSR_LEN-1:0] pin_out,
    output reg [BSR_LEN-1:0] core_in,
    output reg isp_mode,
    output reg isp_busy
);
    localparam [31:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    reg [2:0] tck_s_q, tms_s_q, tdi_s_q;
    reg [3:0] st_q;
    reg [`IR_LEN-1:0] ir_sh_q, ir_q;
    reg [31:0] id_sh_q;
    reg byp_q;
    reg [BSR_LEN-1:0] bsr_sh_q, bsr_up_q;
    reg [`ISP_DATA_LEN-1:0] isp_sh_q;
    reg [31:0] stage_cnt_q;
    reg isp_we_q;
    reg [5:0] isp_addr_q;
    reg port_en_q1, port_en_q2;
    reg [3:0] upin_q1, upin_q2;
    reg [BSR_LEN-1:0] pin_q1, pin_q2;
    wire [`ISP_DATA_LEN-1:0] isp_rd;
    wire rise = tck_s_q[1] & ~tck_s_q[2];
    wire fall = ~tck_s_q[1] & tck_s_q[2];
    wire tms_v = tms_s_q[1];
    wire tdi_v = tdi_s_q[1];

    function [3:0] next_state;
        input [3:0] s;
        input m;
        begin
            case (s)
                `ST_RESET: next_state = m ? `ST_RESET : `ST_IDLE;
                `ST_IDLE: next_state = m ? `ST_SEL_DR : `ST_IDLE;
                `ST_SEL_DR: next_state = m ? `ST_SEL_IR : `ST_CAP_DR;
                `ST_CAP_DR: next_state = m ? `ST_EX1_DR : `ST_SH_DR;
                `ST_SH_DR: next_state = m ? `ST_EX1_DR : `ST_SH_DR;
                `ST_EX1_DR: next_state = m ? `ST_UP_DR : `ST_PA_DR;
                `ST_PA_DR: next_state = m ? `ST_EX2_DR : `ST_PA_DR;
                `ST_EX2_DR: next_state = m ? `ST_UP_DR : `ST_SH_DR;
                `ST_UP_DR: next_state = m ? `ST_SEL_DR : `ST_IDLE;
                `ST_SEL_IR: next_state = m ? `ST_RESET : `ST_CAP_IR;
                `ST_CAP_IR: next_state = m ? `ST_EX1_IR : `ST_SH_IR;
                `ST_SH_IR: next_state = m ? `ST_EX1_IR : `ST_SH_IR;
                `ST_EX1_IR: next_state = m ? `ST_UP_IR : `ST_PA_IR;
                `ST_PA_IR: next_state = m ? `ST_EX2_IR : `ST_PA_IR;
                `ST_EX2_IR: next_state = m ? `ST_UP_IR : `ST_SH_IR;
                `ST_UP_IR: next_state = m ? `ST_SEL_DR : `ST_IDLE;
                default: next_state = `ST_RESET;
            endcase
        end
    endfunction

    function is_isp;
        input [`IR_LEN-1:0] i;
        begin
            is_isp = (i == `INS_ISP_ENABLE) || (i == `INS_ISP_DISABLE) ||
                (i == `INS_ISP_PROGRAM) || (i == `INS_ISP_VERIFY);
        end
    endfunction

    wire sel_bsr = (ir_q == `INS_EXTEST) || (ir_q == `INS_SAMPLE);
    wire sel_id = (ir_q == `INS_IDCODE) || (ir_q == `INS_USERCODE);
    wire sel_isp = (ir_q == `INS_ISP_PROGRAM) || (ir_q == `INS_ISP_VERIFY);

    // Only the second and third stages feed logic, keeping the first stage clean.
    always @(posedge clock) begin
        if (!resetn) begin
            tck_s_q <= 3'h0;
            tms_s_q <= 3'h7;
            tdi_s_q <= 3'h7;
            port_en_q1 <= 1'b0;
            port_en_q2 <= 1'b0;
            upin_q1 <= 4'h0;
            upin_q2 <= 4'h0;
            pin_q1 <= {BSR_LEN{1'b0}};
            pin_q2 <= {BSR_LEN{1'b0}};
        end else begin
            tck_s_q <= {tck_s_q[1:0], tck};
            tms_s_q <= {tms_s_q[1:0], tms};
            tdi_s_q <= {tdi_s_q[1:0], tdi};
            port_en_q1 <= port_enable;
            port_en_q2 <= port_en_q1;
            upin_q1 <= user_pin_in;
            upin_q2 <= upin_q1;
            // Pin levels come from outside this clock, so they settle here before capture.
            pin_q1 <= pin_in;
            pin_q2 <= pin_q1;
        end
    end

    // Controller and data paths advance on the sampled rising edge of the test clock.
    always @(posedge clock) begin
        if (!resetn || !port_en_q2) begin
            st_q <= `ST_RESET;
            ir_q <= `INS_IDCODE;
            ir_sh_q <= {`IR_LEN{1'b0}};
            id_sh_q <= 32'h0;
            byp_q <= 1'b0;
            bsr_sh_q <= {BSR_LEN{1'b0}};
            bsr_up_q <= {BSR_LEN{1'b0}};
            isp_sh_q <= {`ISP_DATA_LEN{1'b0}};
            isp_we_q <= 1'b0;
            isp_addr_q <= 6'h0;
        end else begin
            isp_we_q <= 1'b0;
            if (rise) begin
                st_q <= next_state(st_q, tms_v);
                case (st_q)
                    `ST_RESET: begin
                        ir_q <= `INS_IDCODE;
                    end
                    `ST_CAP_IR: begin
                        ir_sh_q <= `IR_CAPTURE;
                    end
                    `ST_SH_IR: begin
                        ir_sh_q <= {tdi_v, ir_sh_q[`IR_LEN-1:1]};
                    end
                    `ST_UP_IR: begin
                        ir_q <= ir_sh_q;
                    end
                    `ST_CAP_DR: begin
                        byp_q <= 1'b0;
                        if (ir_q == `INS_IDCODE) begin
                            id_sh_q <= ID_VALUE;
                        end else if (ir_q == `INS_USERCODE) begin
                            id_sh_q <= USER_CODE;
                        end
                        if (sel_bsr) begin
                            bsr_sh_q <= (ir_q == `INS_EXTEST) ? pin_q2 : core_out;
                        end
                        if (sel_isp) begin
                            isp_sh_q <= isp_rd;
                        end
                    end
                    `ST_SH_DR: begin
                        byp_q <= tdi_v;
                        id_sh_q <= {tdi_v, id_sh_q[31:1]};
                        if (sel_bsr) begin
                            bsr_sh_q <= {tdi_v, bsr_sh_q[BSR_LEN-1:1]};
                        end
                        if (sel_isp) begin
                            isp_sh_q <= {tdi_v, isp_sh_q[`ISP_DATA_LEN-1:1]};
                        end
                    end
                    `ST_UP_DR: begin
                        if (sel_bsr) begin
                            bsr_up_q <= bsr_sh_q;
                        end
                        if (ir_q == `INS_ISP_PROGRAM) begin
                            isp_we_q <= 1'b1;
                        end
                        if (sel_isp) begin
                            isp_addr_q <= isp_addr_q + 6'h01;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    isp_store #(.AW(6), .DW(`ISP_DATA_LEN)) isp_store_i (
        .clock(clock),
        .wr_en(isp_we_q),
        .addr(isp_addr_q),
        .wr_data(isp_sh_q),
        .rd_data(isp_rd)
    );

    // Programming mode switches at once; busy is then held high for a fixed stage time.
    always @(posedge clock) begin
        if (!resetn) begin
            isp_mode <= 1'b0;
            isp_busy <= 1'b0;
            stage_cnt_q <= 32'h0;
        end else if (stage_cnt_q != 32'h0) begin
            stage_cnt_q <= stage_cnt_q - 32'h1;
            if (stage_cnt_q == 32'h1) begin
                isp_busy <= 1'b0;
            end
        end else if (st_q == `ST_UP_IR && rise && is_isp(ir_sh_q)) begin
            if (ir_sh_q == `INS_ISP_ENABLE && !isp_mode) begin
                isp_mode <= 1'b1;
                isp_busy <= 1'b1;
                stage_cnt_q <= STAGE_CYCLES;
            end else if (ir_sh_q == `INS_ISP_DISABLE && isp_mode) begin
                isp_mode <= 1'b0;
                isp_busy <= 1'b1;
                stage_cnt_q <= STAGE_CYCLES;
            end
        end
    end

    // Output drive: data out changes on every test clock falling edge while the port is enabled; its enable is set only in shift states.
    always @(posedge clock) begin
        if (!resetn) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
            pin_out <= {BSR_LEN{1'b0}};
            core_in <= {BSR_LEN{1'b0}};
            user_pin_out <= 4'h0;
            user_pin_oe <= 4'h0;
        end else begin
            if (!port_en_q2) begin
                tdo_oe <= 1'b0;
            end else if (fall) begin
                tdo_oe <= (st_q == `ST_SH_DR) || (st_q == `ST_SH_IR);
                if (st_q == `ST_SH_IR) begin
                    tdo <= ir_sh_q[0];
                end else if (sel_bsr) begin
                    tdo <= bsr_sh_q[0];
                end else if (sel_id) begin
                    tdo <= id_sh_q[0];
                end else if (sel_isp) begin
                    tdo <= isp_sh_q[0];
                end else begin
                    tdo <= byp_q;
                end
            end
            // Boundary cells only steer pins under external test; otherwise core drives.
            pin_out <= (ir_q == `INS_EXTEST) ? bsr_up_q : core_out;
            core_in <= pin_q2;
            // Released pins carry user signals looped back as plain I/O.
            user_pin_out <= upin_q2;
            user_pin_oe <= port_en_q2 ? 4'h0 : 4'hF;
        end
    end
endmodule

// ==== inc/scan_port_defines.vh ====
// Constants for the boundary-scan test port: instruction codes, widths and timings.
`ifndef SCAN_PORT_DEFINES_VH
`define SCAN_PORT_DEFINES_VH
`define IR_LEN 10
`define ID_LEN 32
`define BSR_LEN_DEFAULT 96
`define IR_CAPTURE 10'h001
`define INS_EXTEST 10'h000
`define INS_SAMPLE 10'h055
`define INS_IDCODE 10'h059
`define INS_USERCODE 10'h007
`define INS_BYPASS 10'h3FF
`define INS_ISP_ENABLE 10'h2CC
`define INS_ISP_DISABLE 10'h201
`define INS_ISP_PROGRAM 10'h2F4
`define INS_ISP_VERIFY 10'h205
`define ISP_STAGE_TIME_US 1000
`define CLOCK_MHZ 25
`define ISP_STAGE_CYCLES (`ISP_STAGE_TIME_US * `CLOCK_MHZ)
`define ISP_DATA_LEN 16
`define ID_VERSION 4'h1
`define ID_PART 16'h1234
`define ID_MAKER 11'h2AA
`define USER_CODE_DEFAULT 32'hFFFFFFFF
`define ST_RESET 4'hF
`define ST_IDLE 4'hC
`define ST_SEL_DR 4'h7
`define ST_CAP_DR 4'h6
`define ST_SH_DR 4'h2
`define ST_EX1_DR 4'h1
`define ST_PA_DR 4'h3
`define ST_EX2_DR 4'h0
`define ST_UP_DR 4'h5
`define ST_SEL_IR 4'h4
`define ST_CAP_IR 4'hE
`define ST_SH_IR 4'hA
`define ST_EX1_IR 4'h9
`define ST_PA_IR 4'hB
`define ST_EX2_IR 4'h8
`define ST_UP_IR 4'hD
`endif

// ==== core/isp_store.v ====
// Small memory holding the in-system programming words, with a registered read port.
`timescale 1ns/100ps
module isp_store #(
    parameter AW = 6,
    parameter DW = 16
) (
    input wire clock,
    input wire wr_en,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wr_data,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge clock) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule

// ==== verification/scan_port_checker.sv ====
// Assertions on the boundary-scan test port outputs.
`timescale 1ns/100ps
module scan_port_checker #(
    parameter BSR_LEN = 96,
    parameter STAGE_CYCLES = 25000
) (
    input logic clock,
    input logic resetn,
    input logic port_enable,
    input logic [3:0] user_pin_in,
    input logic [3:0] user_pin_out,
    input logic [3:0] user_pin_oe,
    input logic tdo_oe,
    input logic [BSR_LEN-1:0] core_out,
    input logic [BSR_LEN-1:0] pin_out,
    input logic isp_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Counts how long each programming stage pulse has been high.
    logic [31:0] busy_q;
    always @(posedge clock) begin
        if (!resetn || !isp_busy)
            busy_q <= 32'h0;
        else
            busy_q <= busy_q + 32'h1;
    end
    released_oe_a: assert property (!port_enable [*4] |-> user_pin_oe == 4'hF)
        else $error("user pins not released");
    port_oe_a: assert property (port_enable [*4] |-> user_pin_oe == 4'h0)
        else $error("user pins driven while port in use");
    user_loop_a: assert property (!port_enable [*6] |-> user_pin_out == $past(user_pin_in, 3))
        else $error("user pin level not passed through");
    no_shift_a: assert property (!port_enable [*6] |-> !tdo_oe)
        else $error("test data out driven while port released");
    core_pass_a: assert property (!port_enable [*6] |-> pin_out == $past(core_out))
        else $error("boundary cells disturb pins in reset");
    stage_len_a: assert property ($fell(isp_busy) |-> busy_q == STAGE_CYCLES)
        else $error("programming stage length wrong");
    stage_cap_a: assert property (isp_busy |-> busy_q < STAGE_CYCLES)
        else $error("programming stage too long");
    reset_out_a: assert property ($rose(resetn) |-> pin_out == {BSR_LEN{1'b0}} && !tdo_oe)
        else $error("outputs not cleared by reset");
    cover property ($fell(isp_busy));
    cover property ($rose(tdo_oe));
    cover property (!port_enable [*6]);
endmodule

// ==== verification/jtag_host_model.sv ====
// Behavioural test host that drives the scan port pins and reads test data out.
`timescale 1ns/100ps
module jtag_host_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // The low phase is the longer one, so tdo, which lags the falling edge by
    // several system clocks, has settled before it is sampled.
    // Data out is read between system clock edges, never in the step that updates it.
    task automatic pulse(input logic m, input logic b, output logic q);
        #40;
        tms <= m;
        tdi <= b;
        #150;
        q = tdo;
        #10;
        tck <= 1'b1;
        #120;
        tck <= 1'b0;
    endtask
    task automatic go_reset;
        logic q;
        repeat (5) pulse(1'b1, 1'b0, q);
        pulse(1'b0, 1'b0, q);
    endtask
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        pulse(1'b1, 1'b0, q);
        if (ir)
            pulse(1'b1, 1'b0, q);
        pulse(1'b0, 1'b0, q);
        pulse(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], q);
            dout[i] = q;
        end
        pulse(1'b1, 1'b0, q);
        pulse(1'b0, 1'b0, q);
    endtask
endmodule

// ==== verification/boundary_scan_test_port_tb_top.sv ====
// Testbench for the boundary-scan test port.
`timescale 1ns/100ps
`include "scan_port_defines.vh"
module boundary_scan_test_port_tb_top;
    localparam UC = 32'hA5C30F1E;
    logic clock = 1'b0;
    logic resetn, port_enable, tdo, tdo_oe, isp_mode, isp_busy, tck, tms, tdi;
    logic [3:0] user_pin_in, user_pin_out, user_pin_oe;
    logic [7:0] core_out, pin_in, pin_out, core_in;
    logic [31:0] d;
    int bad_count = 0;
    int n_checks = 0;
    always #20 clock = ~clock;
    boundary_scan_test_port #(.BSR_LEN(8), .STAGE_CYCLES(20), .USER_CODE(UC))
    boundary_scan_test_port_i (.clock(clock), .resetn(resetn), .port_enable(port_enable),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .user_pin_in(user_pin_in), .user_pin_out(user_pin_out), .user_pin_oe(user_pin_oe),
        .core_out(core_out), .pin_in(pin_in), .pin_out(pin_out), .core_in(core_in),
        .isp_mode(isp_mode), .isp_busy(isp_busy));
    // A released data pin shows the inverse of its last level, so a missing drive reads wrong.
    jtag_host_model jtag_host_model_i (.tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo_oe ? tdo : ~tdo));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic load_ir(input logic [9:0] ins);
        jtag_host_model_i.scan(1'b1, 10, {22'h0, ins}, d);
        chk(d[9:0], `IR_CAPTURE);
    endtask
    task automatic stage(input logic mode);
        int i;
        // The stage starts a few system clocks after the test clock edge of the update.
        repeat (3) @(negedge clock);
        chk(isp_busy, 1'b1);
        for (i = 0; i < 100 && isp_busy !== 1'b0; i++)
            @(negedge clock);
        if (i == 100) begin
            bad_count++;
            results();
        end
        chk(isp_mode, mode);
    endtask
    task automatic t_ids;
        jtag_host_model_i.go_reset();
        jtag_host_model_i.scan(1'b0, 32, 32'h0, d);
        chk(d, {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1});
        load_ir(`INS_USERCODE);
        jtag_host_model_i.scan(1'b0, 32, 32'h0, d);
        chk(d, UC);
    endtask
    task automatic t_bypass;
        for (int k = 0; k < 2; k++) begin
            load_ir(k == 0 ? `INS_BYPASS : 10'h123);
            jtag_host_model_i.scan(1'b0, 9, 32'h1A5, d);
            chk(d[8:0], 9'h14A);
        end
    endtask
    task automatic t_boundary;
        @(posedge clock);
        core_out <= 8'h3C;
        pin_in <= 8'h96;
        load_ir(`INS_SAMPLE);
        jtag_host_model_i.scan(1'b0, 8, 32'h5A, d);
        chk(d[7:0], 8'h3C);
        chk(pin_out, 8'h3C);
        chk(core_in, 8'h96);
        load_ir(`INS_EXTEST);
        // An update reaches the pins a few system clocks after the test clock edge.
        repeat (3) @(negedge clock);
        chk(pin_out, 8'h5A);
        jtag_host_model_i.scan(1'b0, 8, 32'hC3, d);
        chk(d[7:0], 8'h96);
        repeat (3) @(negedge clock);
        chk(pin_out, 8'hC3);
    endtask
    task automatic t_isp;
        load_ir(`INS_ISP_ENABLE);
        stage(1'b1);
        load_ir(`INS_ISP_PROGRAM);
        jtag_host_model_i.scan(1'b0, 16, 32'hBEEF, d);
        load_ir(`INS_ISP_VERIFY);
        jtag_host_model_i.scan(1'b0, 16, 32'h0, d);
        chk(d[15:0], 16'hBEEF);
        load_ir(`INS_ISP_DISABLE);
        stage(1'b0);
    endtask
    task automatic t_release;
        @(posedge clock);
        port_enable <= 1'b0;
        user_pin_in <= 4'hA;
        repeat (10) @(posedge clock);
        chk(user_pin_oe, 4'hF);
        chk(user_pin_out, 4'hA);
        chk(tdo_oe, 1'b0);
        port_enable <= 1'b1;
        repeat (8) @(posedge clock);
        chk(user_pin_oe, 4'h0);
    endtask
    initial begin
        resetn = 1'b0;
        port_enable = 1'b1;
        user_pin_in = 4'h0;
        core_out = 8'h0;
        pin_in = 8'h0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        t_ids();
        t_bypass();
        t_boundary();
        t_isp();
        t_release();
        results();
    end
endmodule
bind boundary_scan_test_port scan_port_checker #(.BSR_LEN(BSR_LEN), .STAGE_CYCLES(STAGE_CYCLES))
scan_port_checker_i (.clock(clock), .resetn(resetn), .port_enable(port_enable),
    .user_pin_in(user_pin_in), .user_pin_out(user_pin_out), .user_pin_oe(user_pin_oe),
    .tdo_oe(tdo_oe), .core_out(core_out), .pin_out(pin_out), .isp_busy(isp_busy));
